// File: logic/dmt_pkg.sv
/*
 * dmt_pkg: register map, field positions, reset values, clock-select codes and prescale
 * counts for the dual mode compare timer.
 * Assumes an 8-bit on-chip register bus with 16-bit byte addresses.
 */
package dmt_pkg;

    // register byte addresses
    localparam logic [15:0] DMT_ADDR_CONTROL        = 16'hffb6;
    localparam logic [15:0] DMT_ADDR_CONTROL_STATUS = 16'hffb7;
    localparam logic [15:0] DMT_ADDR_COUNTER_HIGH   = 16'hffb8;
    localparam logic [15:0] DMT_ADDR_COUNTER_LOW    = 16'hffb9;
    localparam logic [15:0] DMT_ADDR_COMPARE_HIGH   = 16'hffba;
    localparam logic [15:0] DMT_ADDR_COMPARE_LOW    = 16'hffbb;
    localparam logic [15:0] DMT_ADDR_CLOCK_STOP     = 16'hfffa;

    // values after reset and fixed read values
    localparam logic [7:0] DMT_RST_CONTROL        = 8'h00;
    localparam logic [7:0] DMT_RST_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] DMT_RST_COUNTER        = 8'h00;
    localparam logic [7:0] DMT_RST_COMPARE        = 8'hff;
    localparam logic [7:0] DMT_RST_CLOCK_STOP     = 8'hff;
    localparam logic [7:0] DMT_READ_WRITE_ONLY    = 8'hff;
    localparam logic [7:0] DMT_READ_UNMAPPED      = 8'h00;

    // timer_control fields
    localparam int DMT_HIGH_OUTPUT_LEVEL     = 7;
    localparam int DMT_HIGH_CLOCK_SELECT_TOP = 6;
    localparam int DMT_HIGH_CLOCK_SELECT_LSB = 4;
    localparam int DMT_LOW_OUTPUT_LEVEL      = 3;
    localparam int DMT_LOW_CLOCK_SELECT_LSB  = 0;

    // timer_control_status fields
    localparam int DMT_HIGH_OVERFLOW_FLAG       = 7;
    localparam int DMT_HIGH_MATCH_FLAG          = 6;
    localparam int DMT_HIGH_OVERFLOW_IRQ_ENABLE = 5;
    localparam int DMT_HIGH_MATCH_CLEAR_ENABLE  = 4;
    localparam int DMT_LOW_OVERFLOW_FLAG        = 3;
    localparam int DMT_LOW_MATCH_FLAG           = 2;
    localparam int DMT_LOW_OVERFLOW_IRQ_ENABLE  = 1;
    localparam int DMT_LOW_MATCH_CLEAR_ENABLE   = 0;
    localparam logic [7:0] DMT_FLAG_MASK        = 8'hcc;

    // module_clock_stop: this timer's standby bit, 0 = standby
    localparam int DMT_STANDBY_BIT = 2;

    // clock-select encodings
    localparam logic [2:0] DMT_CKS_DIV32  = 3'h4;
    localparam logic [2:0] DMT_CKS_DIV16  = 3'h5;
    localparam logic [2:0] DMT_CKS_DIV4   = 3'h6;
    localparam logic [2:0] DMT_CKS_SUBDIV = 3'h7;

    // prescale ratios
    localparam int DMT_SYS_DIV_MAX = 32;
    localparam int DMT_SYS_DIV_MID = 16;
    localparam int DMT_SYS_DIV_MIN = 4;
    localparam int DMT_SUB_DIV     = 4;

    // pick the counting tick named by a 3-bit clock-select field
    function automatic logic dmt_sel_tick(input logic [2:0] sel,
                                          input logic t32,
                                          input logic t16,
                                          input logic t4,
                                          input logic tw4);
        logic r;
        r = 1'b0;
        if (sel == DMT_CKS_DIV32) begin
            r = t32;
        end else if (sel == DMT_CKS_DIV16) begin
            r = t16;
        end else if (sel == DMT_CKS_DIV4) begin
            r = t4;
        end else if (sel == DMT_CKS_SUBDIV) begin
            r = tw4;
        end
        return r;
    endfunction : dmt_sel_tick

endpackage : dmt_pkg

// File: logic/dmt_prescaler.sv
/*
 * dmt_prescaler: one-cycle counting ticks at the system clock divided by 32, 16 and 4,
 * and at the sub-clock divided by 4.
 * Assumes sub_clk_pin is asynchronous to sys_clk and much slower than it.
 */
`timescale 1ns/1ps
`default_nettype none
module dmt_prescaler
    import dmt_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic sys_run,
    input  wire logic sub_clk_pin,
    output logic      tick_div32,
    output logic      tick_div16,
    output logic      tick_div4,
    output logic      tick_subdiv
);

    logic [4:0] sys_count;
    logic [2:0] sub_sync;
    logic       sub_level;
    logic [1:0] sub_count;

    // free-running divider; ticks stop while the system clock is nominally halted
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_count <= 5'h00;
        end else if (sys_run) begin
            sys_count <= sys_count + 5'h01;
        end
    end

    assign tick_div32 = sys_run && (sys_count == 5'(DMT_SYS_DIV_MAX - 1));
    assign tick_div16 = sys_run && (sys_count[3:0] == 4'(DMT_SYS_DIV_MID - 1));
    assign tick_div4  = sys_run && (sys_count[1:0] == 2'(DMT_SYS_DIV_MIN - 1)); // RQ18

    // three-stage synchroniser; a level counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_sync  <= 3'h0;
            sub_level <= 1'b0;
        end else begin
            sub_sync <= {sub_sync[1:0], sub_clk_pin};
            if (sub_sync[2] == sub_sync[1]) begin
                sub_level <= sub_sync[2];
            end
        end
    end

    // sub-clock rising edges counted by four; keeps going in low-power modes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_count   <= 2'h0;
            tick_subdiv <= 1'b0;
        end else begin
            tick_subdiv <= 1'b0;
            if (sub_sync[2] == sub_sync[1] && sub_sync[2] && !sub_level) begin
                sub_count <= sub_count + 2'h1;
                if (sub_count == 2'(DMT_SUB_DIV - 1)) begin
                    tick_subdiv <= 1'b1; // RQ19
                end
            end
        end
    end

endmodule : dmt_prescaler
`default_nettype wire

// File: logic/dmt_timer.sv
/*
 * dmt_timer: a 16-bit up-counter with output compare that can split into two 8-bit timers,
 * with overflow and match flags, interrupt request pulses and two toggle output pins.
 * Assumes a single-master 8-bit register bus with one-cycle read and write strobes and an
 * interrupt controller outside that holds the request flags and their enables.
 */
// Contract
// [RQ1] high select top 0: one 16-bit counter
// [RQ2] high select top 1: two independent 8-bit counters
// [RQ3] 16-bit: high counts on low overflow
// [RQ4] 16-bit wrap sets high overflow flag
// [RQ5] 16-bit overflow requests high irq if enabled
// [RQ6] 8-bit: each wrap sets own overflow flag
// [RQ7] 8-bit overflow requests own irq if enabled
// [RQ8] 16-bit match sets high flag and irq
// [RQ9] 8-bit match sets own flag and irq
// [RQ10] 16-bit match clears counter when enabled
// [RQ11] 8-bit match clears own counter when enabled
// [RQ12] 16-bit match toggles high pin; level settable
// [RQ13] 8-bit matches toggle own pins; levels settable
// [RQ14] counters readable, writable; 16-bit via holding register
// [RQ15] compares readable, writable; 16-bit via holding register
// [RQ16] reset clears both counters
// [RQ17] reset sets both compares to all ones
// [RQ18] four clocks: sys/32, sys/16, sys/4, sub/4
// [RQ19] sub-clock source counts in low-power modes
// [RQ20] module standby halts timer independently
// [RQ21] low select: stopped, prohibited, four sources
// [RQ22] flags cleared by write 0 after read 1
// [RQ23] output-level write drives pin immediately
// [RQ24] match toggle inverts current pin level
// [RQ25] standby bit 0 stops counting, keeps registers
`timescale 1ns/1ps
`default_nettype none
module dmt_timer
    import dmt_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    input  wire logic        low_power_mode,
    input  wire logic        sub_clk_pin,
    output logic             high_toggle_pin,
    output logic             low_toggle_pin,
    output logic             high_irq_set,
    output logic             low_irq_set
);

    logic [7:0]  timer_control;
    logic [7:0]  timer_control_status;
    logic [7:0]  module_clock_stop;
    logic [7:0]  counter_high;
    logic [7:0]  counter_low;
    logic [7:0]  compare_high;
    logic [7:0]  compare_low;
    logic [7:0]  hold_temp;
    logic [7:0]  flag_armed;
    logic        match_high_q;
    logic        match_low_q;

    logic        mode16;
    logic        running;
    logic        tick_div32;
    logic        tick_div16;
    logic        tick_div4;
    logic        tick_subdiv;
    logic        low_tick;
    logic        high_tick;
    logic [15:0] combined_counter;
    logic [15:0] combined_compare;
    logic        match_high;
    logic        match_low;
    logic        match_high_evt;
    logic        match_low_evt;
    logic        ovf_high_evt;
    logic        ovf_low_evt;
    logic [7:0]  next_counter_high;
    logic [7:0]  next_counter_low;
    logic [7:0]  flag_set;

    logic        wr_control;
    logic        wr_status;
    logic        wr_cnt_high;
    logic        wr_cnt_low;
    logic        wr_cmp_high;
    logic        wr_cmp_low;
    logic        wr_stop;
    logic        rd_status;

    // write strobes per register and the status read strobe
    assign wr_control  = bus_wr && (bus_addr == DMT_ADDR_CONTROL);
    assign wr_status   = bus_wr && (bus_addr == DMT_ADDR_CONTROL_STATUS);
    assign wr_cnt_high = bus_wr && (bus_addr == DMT_ADDR_COUNTER_HIGH);
    assign wr_cnt_low  = bus_wr && (bus_addr == DMT_ADDR_COUNTER_LOW);
    assign wr_cmp_high = bus_wr && (bus_addr == DMT_ADDR_COMPARE_HIGH);
    assign wr_cmp_low  = bus_wr && (bus_addr == DMT_ADDR_COMPARE_LOW);
    assign wr_stop     = bus_wr && (bus_addr == DMT_ADDR_CLOCK_STOP);
    assign rd_status   = bus_rd && (bus_addr == DMT_ADDR_CONTROL_STATUS);

    // mode and run state
    assign mode16  = !timer_control[DMT_HIGH_CLOCK_SELECT_TOP];  // RQ1 RQ2
    assign running = module_clock_stop[DMT_STANDBY_BIT];          // RQ20 RQ25

    // system-clock ticks are withheld in low-power modes, the sub-clock tick is not
    dmt_prescaler u_prescaler (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .sys_run     (!low_power_mode),
        .sub_clk_pin (sub_clk_pin),
        .tick_div32  (tick_div32),
        .tick_div16  (tick_div16),
        .tick_div4   (tick_div4),
        .tick_subdiv (tick_subdiv)
    );

    // counting ticks; prohibited select codes behave as stopped
    always_comb begin
        low_tick = running && dmt_sel_tick(
            timer_control[DMT_LOW_CLOCK_SELECT_LSB +: 3],
            tick_div32, tick_div16, tick_div4, tick_subdiv);   // RQ21 RQ19
        if (mode16) begin
            high_tick = low_tick && (counter_low == 8'hff);    // RQ3
        end else begin
            high_tick = running && dmt_sel_tick(
                timer_control[DMT_HIGH_CLOCK_SELECT_LSB +: 3],
                tick_div32, tick_div16, tick_div4, tick_subdiv); // RQ2
        end
    end

    assign combined_counter = {counter_high, counter_low};
    assign combined_compare = {compare_high, compare_low};

    // continuous equality; a match event is the first cycle of equality so pins toggle once
    assign match_high = mode16 ? (combined_counter == combined_compare)
                               : (counter_high == compare_high);  // RQ8 RQ9
    assign match_low  = !mode16 && (counter_low == compare_low);  // RQ9
    assign match_high_evt = match_high && !match_high_q;
    assign match_low_evt  = match_low && !match_low_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_high_q <= 1'b0;
            match_low_q  <= 1'b0;
        end else begin
            match_high_q <= match_high;
            match_low_q  <= match_low;
        end
    end

    // next counter values and overflow events; a match-clear pre-empts the wrap
    always_comb begin
        next_counter_high = counter_high;
        next_counter_low  = counter_low;
        ovf_high_evt      = 1'b0;
        ovf_low_evt       = 1'b0;
        if (mode16) begin
            if (low_tick) begin
                if (match_high && timer_control_status[DMT_HIGH_MATCH_CLEAR_ENABLE]) begin
                    next_counter_high = 8'h00;                  // RQ10
                    next_counter_low  = 8'h00;
                end else begin
                    {next_counter_high, next_counter_low} = combined_counter + 16'h0001;
                    ovf_high_evt = (combined_counter == 16'hffff); // RQ4
                end
            end
        end else begin
            if (high_tick) begin
                if (match_high && timer_control_status[DMT_HIGH_MATCH_CLEAR_ENABLE]) begin
                    next_counter_high = 8'h00;                  // RQ11
                end else begin
                    next_counter_high = counter_high + 8'h01;
                    ovf_high_evt = (counter_high == 8'hff);     // RQ6
                end
            end
            if (low_tick) begin
                if (match_low && timer_control_status[DMT_LOW_MATCH_CLEAR_ENABLE]) begin
                    next_counter_low = 8'h00;                   // RQ11
                end else begin
                    next_counter_low = counter_low + 8'h01;
                    ovf_low_evt = (counter_low == 8'hff);       // RQ6
                end
            end
        end
    end

    // counters: a cpu write takes precedence over a count in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_high <= DMT_RST_COUNTER;                    // RQ16
            counter_low  <= DMT_RST_COUNTER;
        end else if (mode16 && wr_cnt_low) begin
            counter_high <= hold_temp;                          // RQ14
            counter_low  <= bus_wdata;
        end else begin
            if (!mode16 && wr_cnt_high) begin
                counter_high <= bus_wdata;                      // RQ14
            end else if (!(mode16 && wr_cnt_high)) begin
                counter_high <= next_counter_high;
            end
            if (!mode16 && wr_cnt_low) begin
                counter_low <= bus_wdata;
            end else begin
                counter_low <= next_counter_low;
            end
        end
    end

    // compares: in 16-bit mode the high byte waits in the holding register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_high <= DMT_RST_COMPARE;                    // RQ17
            compare_low  <= DMT_RST_COMPARE;
        end else if (mode16) begin
            if (wr_cmp_low) begin
                compare_high <= hold_temp;                      // RQ15
                compare_low  <= bus_wdata;
            end
        end else begin
            if (wr_cmp_high) begin
                compare_high <= bus_wdata;                      // RQ15
            end
            if (wr_cmp_low) begin
                compare_low <= bus_wdata;
            end
        end
    end

    // holding register: high-byte write parks data, high-byte read snapshots the low byte
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_temp <= 8'h00;
        end else if (mode16) begin
            if (wr_cnt_high || wr_cmp_high) begin
                hold_temp <= bus_wdata;                         // RQ14 RQ15
            end else if (bus_rd && bus_addr == DMT_ADDR_COUNTER_HIGH) begin
                hold_temp <= counter_low;                       // RQ14
            end else if (bus_rd && bus_addr == DMT_ADDR_COMPARE_HIGH) begin
                hold_temp <= compare_low;                       // RQ15
            end
        end
    end

    // control and standby registers; both keep their contents through standby
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_control     <= DMT_RST_CONTROL;
            module_clock_stop <= DMT_RST_CLOCK_STOP;
        end else begin
            if (wr_control) begin
                timer_control <= bus_wdata;
            end
            if (wr_stop) begin
                module_clock_stop <= bus_wdata;                 // RQ25
            end
        end
    end

    // hardware set conditions for the four flags
    always_comb begin
        flag_set = 8'h00;
        flag_set[DMT_HIGH_OVERFLOW_FLAG] = ovf_high_evt;       // RQ4 RQ6
        flag_set[DMT_HIGH_MATCH_FLAG]    = match_high_evt;     // RQ8 RQ9
        flag_set[DMT_LOW_OVERFLOW_FLAG]  = ovf_low_evt;        // RQ6
        flag_set[DMT_LOW_MATCH_FLAG]     = match_low_evt;      // RQ9
    end

    // flags clear only on a 0 write after being read as 1; a set in that cycle wins
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_control_status <= DMT_RST_CONTROL_STATUS;
            flag_armed           <= 8'h00;
        end else begin
            if (wr_status) begin
                timer_control_status <= (bus_wdata & ~DMT_FLAG_MASK)
                    | (timer_control_status & DMT_FLAG_MASK
                       & ~(flag_armed & ~bus_wdata))
                    | flag_set;                                 // RQ22
                flag_armed <= 8'h00;
            end else begin
                timer_control_status <= timer_control_status | flag_set;
                if (rd_status) begin
                    flag_armed <= timer_control_status & DMT_FLAG_MASK; // RQ22
                end
            end
        end
    end

    // request pulses to the interrupt controller, which applies its own enables
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_irq_set <= 1'b0;
            low_irq_set  <= 1'b0;
        end else begin
            high_irq_set <= match_high_evt                     // RQ8 RQ9
                || (ovf_high_evt
                    && timer_control_status[DMT_HIGH_OVERFLOW_IRQ_ENABLE]); // RQ5 RQ7
            low_irq_set  <= match_low_evt                      // RQ9
                || (ovf_low_evt
                    && timer_control_status[DMT_LOW_OVERFLOW_IRQ_ENABLE]);  // RQ7
        end
    end

    // output pins: level write wins over a toggle in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_toggle_pin <= 1'b0;
            low_toggle_pin  <= 1'b0;
        end else begin
            if (wr_control) begin
                high_toggle_pin <= bus_wdata[DMT_HIGH_OUTPUT_LEVEL]; // RQ23
            end else if (match_high_evt) begin
                high_toggle_pin <= !high_toggle_pin;            // RQ12 RQ24
            end
            if (wr_control) begin
                low_toggle_pin <= bus_wdata[DMT_LOW_OUTPUT_LEVEL];   // RQ23
            end else if (match_low_evt) begin
                low_toggle_pin <= !low_toggle_pin;              // RQ13 RQ24
            end
        end
    end

    // read data, registered; the write-only control register reads as all ones
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata <= DMT_READ_UNMAPPED;
        end else if (bus_rd) begin
            if (bus_addr == DMT_ADDR_CONTROL) begin
                bus_rdata <= DMT_READ_WRITE_ONLY;
            end else if (bus_addr == DMT_ADDR_CONTROL_STATUS) begin
                bus_rdata <= timer_control_status;
            end else if (bus_addr == DMT_ADDR_COUNTER_HIGH) begin
                bus_rdata <= counter_high;                      // RQ14
            end else if (bus_addr == DMT_ADDR_COUNTER_LOW) begin
                bus_rdata <= mode16 ? hold_temp : counter_low;  // RQ14
            end else if (bus_addr == DMT_ADDR_COMPARE_HIGH) begin
                bus_rdata <= compare_high;                      // RQ15
            end else if (bus_addr == DMT_ADDR_COMPARE_LOW) begin
                bus_rdata <= mode16 ? hold_temp : compare_low;  // RQ15
            end else if (bus_addr == DMT_ADDR_CLOCK_STOP) begin
                bus_rdata <= module_clock_stop;
            end else begin
                bus_rdata <= DMT_READ_UNMAPPED;
            end
        end
    end

endmodule : dmt_timer
`default_nettype wire

// File: verification/dmt_timer_monitor.sv
/* dmt_timer_monitor: port-level assertions for the dual mode compare timer.
   Assumes one clock domain and the one-cycle bus strobes of the timer. */
`timescale 1ns/1ps
`default_nettype none
module dmt_timer_monitor (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        high_toggle_pin,
    input wire logic        low_toggle_pin,
    input wire logic        high_irq_set,
    input wire logic        low_irq_set
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // control write and address decode; a toggle without a control write needs a match
    wire logic cw  = bus_wr && bus_addr == 16'hffb6;
    wire logic hit = bus_addr inside {[16'hffb6:16'hffbb], 16'hfffa};
    high_level_a: assert property (cw |=> high_toggle_pin == $past(bus_wdata[7]))
        else $error("high pin not at written level");
    low_level_a: assert property (cw |=> low_toggle_pin == $past(bus_wdata[3]))
        else $error("low pin not at written level");
    unmapped_read_a: assert property (bus_rd && !hit |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    control_read_a: assert property (bus_rd && bus_addr == 16'hffb6 |=> bus_rdata == 8'hff)
        else $error("control read not all ones");
    rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    high_toggle_a: assert property ($changed(high_toggle_pin) && !$past(cw) |-> high_irq_set)
        else $error("high pin toggled without match");
    low_toggle_a: assert property ($changed(low_toggle_pin) && !$past(cw) |-> low_irq_set)
        else $error("low pin toggled without match");
    reset_state_a: assert property ($rose(reset_n) |-> !high_toggle_pin &&
        !low_toggle_pin && bus_rdata == 8'h00) else $error("outputs not idle after reset");
    cover property (high_irq_set);
    cover property (low_irq_set);
    cover property (cw ##1 high_toggle_pin);
endmodule : dmt_timer_monitor
bind dmt_timer dmt_timer_monitor u_mon (.sys_clk, .reset_n, .bus_addr, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .high_toggle_pin, .low_toggle_pin, .high_irq_set, .low_irq_set);
`default_nettype wire

// File: verification/dmt_cpu_model.sv
/* dmt_cpu_model: processor side of the timer register bus, as callable tasks.
   Assumes the timer samples strobes on the rising edge; this side moves on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module dmt_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  bus_rdata,
    output logic      [15:0] bus_addr,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic      [7:0]  bus_wdata
);
    // idle bus starts at zero; each access leaves the address, and a write its data, inverted so no stale value looks valid
    initial begin
        bus_addr = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end
    // one-cycle write; in 16-bit mode the caller writes the high byte first
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge sys_clk);
        bus_wr = 1'b0;
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask : wr
    // data is taken half a cycle after the strobe edge; flags are cleared only after a read
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge sys_clk);
        bus_rd = 1'b0;
        bus_addr = ~a;
        d = bus_rdata;
    endtask : rd
endmodule : dmt_cpu_model
`default_nettype wire

// File: verification/dmt_timer_tb_top.sv
/* dmt_timer_tb_top: self-checking bench for the dual mode compare timer.
   Assumes the processor model drives the bus and the bench owns clocks and reset. */
`timescale 1ns/1ps
`default_nettype none
module dmt_timer_tb_top;
    logic        sys_clk, reset_n, low_power_mode, sub_clk_pin, bus_wr, bus_rd;
    logic        high_toggle_pin, low_toggle_pin, high_irq_set, low_irq_set;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, v;
    int          n_errors = 0;
    int          checked = 0;
    // address beside its expected read value after reset, the one unmapped place last
    logic [23:0] rows [8] = '{24'hffb6ff, 24'hffb700, 24'hffb800, 24'hffb900,
                              24'hffbaff, 24'hffbbff, 24'hfffaff, 24'hffbc00};
    dmt_timer uut (.sys_clk, .reset_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
        .low_power_mode, .sub_clk_pin, .high_toggle_pin, .low_toggle_pin, .high_irq_set,
        .low_irq_set);
    dmt_cpu_model cpu (.sys_clk, .bus_rdata, .bus_addr, .bus_wr, .bus_rd, .bus_wdata);
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        cpu.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask : rdchk
    // bounded wait for a one-cycle request pulse
    task automatic wait_irq(input logic hi);
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            #1;
            if (hi ? high_irq_set : low_irq_set) return;
        end
        chk("irq pulse", 8'h01, 8'h00);
        finish_test();
    endtask : wait_irq
    // the count must move, or stay, over 200 cycles
    task automatic measure(input logic moving);
        logic [7:0] w;
        cpu.rd(16'hffb9, w);
        repeat (200) @(posedge sys_clk);
        cpu.rd(16'hffb9, v);
        chk("counter moving", {7'h00, moving}, {7'h00, v !== w});
    endtask : measure
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // sub-clock at half the sys/4 rate, its edges on falling sys_clk edges
    initial begin
        sub_clk_pin = 1'b0;
        forever #20 sub_clk_pin = ~sub_clk_pin;
    end
    initial begin
        reset_n = 1'b0;
        low_power_mode = 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        cpu.wr(16'hffbc, 8'h55);
        for (int i = 0; i < 8; i++) begin
            rdchk(rows[i][23:8], rows[i][7:0]);
        end
        // eight-bit mode, low half at sys/4, match at 02 clearing the count
        cpu.wr(16'hffb6, 8'h40);
        cpu.wr(16'hffbb, 8'h02);
        cpu.wr(16'hffb7, 8'h01);
        cpu.wr(16'hffb6, 8'h46);
        wait_irq(1'b0);
        chk("low pin", 8'h01, {7'h00, low_toggle_pin});
        wait_irq(1'b0);
        cpu.wr(16'hffb6, 8'h48);
        chk("low pin level", 8'h01, {7'h00, low_toggle_pin});
        // a clear before any read, and ones written to flags, change nothing
        cpu.wr(16'hffb7, 8'h01);
        rdchk(16'hffb7, 8'h05);
        cpu.wr(16'hffb7, 8'h0d);
        rdchk(16'hffb7, 8'h05);
        cpu.wr(16'hffb7, 8'h01);
        rdchk(16'hffb7, 8'h01);
        // sixteen-bit mode: both halves through the holding register, high first
        cpu.wr(16'hffb6, 8'h00);
        cpu.wr(16'hffb7, 8'h20);
        cpu.wr(16'hffba, 8'hff);
        cpu.wr(16'hffbb, 8'hf8);
        cpu.wr(16'hffb8, 8'hff);
        cpu.wr(16'hffb9, 8'hf0);
        rdchk(16'hffba, 8'hff);
        rdchk(16'hffbb, 8'hf8);
        cpu.wr(16'hffb6, 8'h86);
        wait_irq(1'b1);
        chk("high pin", 8'h00, {7'h00, high_toggle_pin});
        wait_irq(1'b1);
        cpu.wr(16'hffb6, 8'h00);
        rdchk(16'hffb7, 8'he0);
        rdchk(16'hffb8, 8'h00);
        // sources under low-power mode and module standby
        cpu.wr(16'hffb7, 8'h00);
        cpu.wr(16'hffb6, 8'h47);
        low_power_mode = 1'b1;
        measure(1'b1);
        cpu.wr(16'hffb6, 8'h45);
        measure(1'b0);
        low_power_mode = 1'b0;
        cpu.wr(16'hfffa, 8'hfb);
        measure(1'b0);
        cpu.wr(16'hfffa, 8'hff);
        measure(1'b1);
        finish_test();
    end
endmodule : dmt_timer_tb_top
`default_nettype wire
